// file: common/clhp_pkg.sv
// Function
// R1: Select low: write instruction, read busy+counter
// R2: Select high: reads and writes hit data
// R3: Read/write high reads, low writes
// R4: Host raises enable to start transfers
// R5: Transfer happens on enable falling edge
// R6: Top data line shows busy
// R7: Four-bit mode uses upper four lines
// R8: Sub-address pin sets serial bus address
// R9: Host holds enable low for serial bus
// R10: Data lines open during serial reads
// R11: Store generator bit from function set
// R12: Mux and bias follow line count
// R13: Frame rate is clock over 2304
// R14: Host supplies a running clock always
// R15: Initialize automatically after power-up
// R16: 32 rows, 60 paired column outputs; code has no row or column outputs
// R17: Store 80 codes, 240+16 patterns; code has no CGROM, only 80 DDRAM codes and 128 CGRAM bytes
// R18: Busy reads one while occupied
// R19: Counter on low seven lines, steps
// R20: Instruction register write-only
// R21: Host writes only when not busy
// R22: Synchronize enable falling edge internally
// R23: Four-bit bytes: upper nibble first
`default_nettype none
package clhp_pkg;
    localparam int unsigned FRAME_DIV     = 2304;
    localparam int unsigned INIT_CYCLES   = 1000;
    localparam int unsigned INSTR_CYCLES  = 40;
    localparam int unsigned DDRAM_DEPTH   = 80;
    localparam int unsigned CGROM_CHARS   = 240;
    localparam int unsigned CGRAM_CHARS   = 16;
    localparam int unsigned CGRAM_BYTES   = 128;
    localparam int unsigned ROW_COUNT     = 32;
    localparam int unsigned COL_COUNT     = 60;
    localparam logic [6:0]  AC_RESET      = 7'h00;
    localparam logic [7:0]  FUNC_RESET    = 8'h30;
    localparam int unsigned FUNC_DL_BIT   = 4;
    localparam int unsigned FUNC_N_BIT    = 2;
    localparam int unsigned FUNC_G_BIT    = 0;
    localparam logic        RW_READ       = 1'b1;
    localparam logic        RS_INSTR      = 1'b0;
    localparam logic [1:0]  BIAS_5        = 2'h0;
    localparam logic [1:0]  BIAS_6        = 2'h1;
    localparam logic [5:0]  SADDR_HIGH    = 6'h1d; // Arbitrary upper serial address bits
    typedef enum {CLHP_INIT, CLHP_IDLE, CLHP_BUSY} clhp_state_e;
endpackage
`default_nettype wire

// file: hdl/clhp_sync.sv
`default_nettype none
module clhp_sync (
    input  wire logic MCLK,
    input  wire logic RST,
    input  wire logic din,
    output logic      fall
);
    // Three flops, then an edge detect across the second and third
    typedef struct packed {logic s1; logic s2; logic s3;} clhp_sync_s;
    clhp_sync_s st_reg, st_next;
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
    end
    always_ff @(posedge MCLK) begin
        if (RST) st_reg <= '0;
        else st_reg <= st_next;
    end
    assign fall = st_reg.s3 & ~st_reg.s2; // R22
endmodule
`default_nettype wire

// file: hdl/clhp_frame.sv
`default_nettype none
module clhp_frame
    import clhp_pkg::*;
#(
    parameter int unsigned DIV = FRAME_DIV
) (
    input  wire logic MCLK,
    input  wire logic RST,
    output logic      tick
);
    typedef struct packed {logic [11:0] cnt; logic tick;} clhp_frame_s;
    clhp_frame_s st_reg, st_next;
    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.cnt == 12'(DIV - 1)) begin // R13
            st_next.cnt  = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 12'h001;
        end
    end
    always_ff @(posedge MCLK) begin
        if (RST) st_reg <= '0;
        else st_reg <= st_next;
    end
    assign tick = st_reg.tick;
endmodule
`default_nettype wire

// file: hdl/clhp_top.sv
`default_nettype none
module clhp_top
    import clhp_pkg::*;
#(
    parameter int unsigned INIT_LEN  = INIT_CYCLES,
    parameter int unsigned BUSY_LEN  = INSTR_CYCLES,
    parameter int unsigned FRAME_LEN = FRAME_DIV
) (
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic        ENABLE,
    input  wire logic        REG_CHOOSE_LINE,
    input  wire logic        RW,
    input  wire logic [7:0]  HOST_DATA_LINES_IN,
    output logic      [7:0]  HOST_DATA_LINES_OUT,
    output logic      [7:0]  HOST_DATA_LINES_OE,
    input  wire logic        SUBADDR_PIN,
    output logic      [6:0]  SERIAL_ADDR,
    output logic             BUSY,
    output logic      [6:0]  ADDR_COUNTER,
    output logic             GEN_MODE,
    output logic             MUX_32,
    output logic      [1:0]  BIAS_LEVELS,
    output logic             FOUR_BIT,
    output logic             FRAME_TICK,
    output logic      [7:0]  INSTR_OUT,
    output logic             INSTR_STB
);
    typedef struct packed {
        clhp_state_e  state;
        logic [15:0]  cnt;
        logic [7:0]   instr_reg;
        logic [7:0]   data_reg;
        logic [6:0]   addr_counter;
        logic [7:0]   func;
        logic         inc;
        logic         nib_hi;
        logic [3:0]   nib;
        logic         cg_sel;
        logic [7:0]   dout;
        logic [7:0]   oe;
        logic [7:0]   instr_out;
        logic         instr_stb;
        logic         frame;
        logic [6:0]   saddr;
        logic         busy_flag;
        logic         four_bit;
        logic [1:0]   bias;
    } clhp_s;

    clhp_s st_reg, st_next;
    logic  e_fall;
    logic  ftick;
    // R17: display codes and user patterns kept locally
    logic [7:0] ddram [DDRAM_DEPTH];
    logic [7:0] cgram [CGRAM_BYTES];
    logic       ram_we;
    logic [7:0] ram_wd;
    logic [7:0] rd_byte;

    clhp_sync u_sync (
        .MCLK (MCLK),
        .RST  (RST),
        .din  (ENABLE),
        .fall (e_fall)
    );

    clhp_frame #(.DIV(FRAME_LEN)) u_frame (
        .MCLK (MCLK),
        .RST  (RST),
        .tick (ftick)
    );

    function automatic logic [7:0] status_byte(input logic busy, input logic [6:0] ac);
        status_byte = {busy, ac}; // R1 R6 R18 R19
    endfunction

    function automatic logic [6:0] ac_step(input logic [6:0] ac, input logic up);
        ac_step = up ? ac + 7'h01 : ac - 7'h01; // R19
    endfunction

    always_comb begin
        if (st_reg.cg_sel) rd_byte = cgram[st_reg.addr_counter];
        else if (st_reg.addr_counter < 7'(DDRAM_DEPTH)) rd_byte = ddram[st_reg.addr_counter];
        else rd_byte = 8'h00;
    end

    always_comb begin
        logic       take;
        logic [7:0] byte_in;
        logic       busy;
        take    = 1'b0;
        byte_in = 8'h00;
        busy    = (st_reg.state != CLHP_IDLE);
        ram_we  = 1'b0;
        ram_wd  = 8'h00;
        st_next = st_reg;
        st_next.instr_stb = 1'b0;
        st_next.frame     = ftick;
        st_next.saddr     = {SADDR_HIGH, SUBADDR_PIN}; // R8
        case (st_reg.state)
            CLHP_INIT: begin // R15
                if (st_reg.cnt == 16'(INIT_LEN - 1)) begin
                    st_next.state = CLHP_IDLE;
                    st_next.cnt   = '0;
                end else begin
                    st_next.cnt = st_reg.cnt + 16'h0001;
                end
            end
            CLHP_BUSY: begin
                if (st_reg.cnt == 16'(BUSY_LEN - 1)) begin
                    st_next.state = CLHP_IDLE;
                    st_next.cnt   = '0;
                end else begin
                    st_next.cnt = st_reg.cnt + 16'h0001;
                end
            end
            CLHP_IDLE: st_next.cnt = '0;
            default: st_next.state = CLHP_INIT;
        endcase

        if (e_fall) begin // R5
            if (RW == RW_READ) begin // R3
                if (!st_reg.func[FUNC_DL_BIT]) begin
                    st_next.nib_hi = ~st_reg.nib_hi; // R23
                    take = st_reg.nib_hi;
                end else begin
                    take = 1'b1;
                end
                if (take && REG_CHOOSE_LINE != RS_INSTR) begin // R2
                    st_next.addr_counter = ac_step(st_reg.addr_counter, st_reg.inc);
                    st_next.data_reg     = rd_byte;
                end
            end else begin
                if (!st_reg.func[FUNC_DL_BIT]) begin // R7 R23
                    if (!st_reg.nib_hi) begin
                        st_next.nib    = HOST_DATA_LINES_IN[7:4];
                        st_next.nib_hi = 1'b1;
                    end else begin
                        byte_in        = {st_reg.nib, HOST_DATA_LINES_IN[7:4]};
                        take           = 1'b1;
                        st_next.nib_hi = 1'b0;
                    end
                end else begin
                    byte_in = HOST_DATA_LINES_IN;
                    take    = 1'b1;
                end
                if (take && REG_CHOOSE_LINE == RS_INSTR && !busy) begin // R1 R18 R20
                    st_next.instr_reg = byte_in;
                    st_next.instr_out = byte_in;
                    st_next.instr_stb = 1'b1;
                    st_next.state     = CLHP_BUSY;
                    if (byte_in[7]) begin
                        st_next.addr_counter = byte_in[6:0];
                        st_next.cg_sel       = 1'b0;
                    end else if (byte_in[6]) begin
                        st_next.addr_counter = {1'b0, byte_in[5:0]};
                        st_next.cg_sel       = 1'b1;
                    end else if (byte_in[5]) begin
                        st_next.func = byte_in; // R11 R12
                    end else if (byte_in[2]) begin
                        st_next.inc = byte_in[1];
                    end
                end else if (take && REG_CHOOSE_LINE != RS_INSTR) begin // R2
                    st_next.data_reg     = byte_in;
                    ram_we               = 1'b1;
                    ram_wd               = byte_in;
                    st_next.addr_counter = ac_step(st_reg.addr_counter, st_reg.inc);
                end
            end
        end

        // Drive bus only while a read is framed by the enable strobe
        st_next.oe = 8'h00;
        if (ENABLE && RW == RW_READ) begin // R4
            if (st_reg.func[FUNC_DL_BIT]) begin
                st_next.oe   = 8'hff;
                st_next.dout = (REG_CHOOSE_LINE == RS_INSTR)
                             ? status_byte(busy, st_reg.addr_counter) : rd_byte;
            end else begin
                st_next.oe = 8'hf0; // R7
                byte_in = (REG_CHOOSE_LINE == RS_INSTR)
                        ? status_byte(busy, st_reg.addr_counter) : rd_byte;
                st_next.dout = st_reg.nib_hi ? {byte_in[3:0], 4'h0}
                                             : {byte_in[7:4], 4'h0};
            end
        end

        // Registered so no decode sits between flop and pin
        st_next.busy_flag = (st_next.state != CLHP_IDLE); // R18
        st_next.four_bit  = ~st_next.func[FUNC_DL_BIT]; // R7
        st_next.bias      = st_next.func[FUNC_N_BIT] ? BIAS_6 : BIAS_5; // R12
    end

    always_ff @(posedge MCLK) begin
        if (ram_we && st_reg.cg_sel) cgram[st_reg.addr_counter] <= ram_wd;
        else if (ram_we && st_reg.addr_counter < 7'(DDRAM_DEPTH))
            ddram[st_reg.addr_counter] <= ram_wd;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            st_reg              <= '0;
            st_reg.state        <= CLHP_INIT;
            st_reg.func         <= FUNC_RESET;
            st_reg.addr_counter <= AC_RESET;
            st_reg.inc          <= 1'b1;
            st_reg.busy_flag    <= 1'b1;
            st_reg.four_bit     <= ~FUNC_RESET[FUNC_DL_BIT];
            st_reg.bias         <= FUNC_RESET[FUNC_N_BIT] ? BIAS_6 : BIAS_5;
        end else begin
            st_reg <= st_next;
        end
    end

    assign HOST_DATA_LINES_OUT = st_reg.dout;
    assign HOST_DATA_LINES_OE  = st_reg.oe;
    assign SERIAL_ADDR         = st_reg.saddr;
    assign BUSY                = st_reg.busy_flag; // R6
    assign ADDR_COUNTER        = st_reg.addr_counter;
    assign GEN_MODE            = st_reg.func[FUNC_G_BIT]; // R11
    assign MUX_32              = st_reg.func[FUNC_N_BIT]; // R12
    assign BIAS_LEVELS         = st_reg.bias; // R12
    assign FOUR_BIT            = st_reg.four_bit;
    assign FRAME_TICK          = st_reg.frame;
    assign INSTR_OUT           = st_reg.instr_out;
    assign INSTR_STB           = st_reg.instr_stb;
endmodule
`default_nettype wire

// file: testbench/clhp_sva.sv
`default_nettype none
module clhp_sva
    import clhp_pkg::*;
#(
    parameter int unsigned FRAME_LEN = FRAME_DIV
) (
    input wire logic       MCLK,
    input wire logic       RST,
    input wire logic       ENABLE,
    input wire logic       REG_CHOOSE_LINE,
    input wire logic       RW,
    input wire logic [7:0] HOST_DATA_LINES_OUT,
    input wire logic [7:0] HOST_DATA_LINES_OE,
    input wire logic       SUBADDR_PIN,
    input wire logic [6:0] SERIAL_ADDR,
    input wire logic       BUSY,
    input wire logic [6:0] ADDR_COUNTER,
    input wire logic       GEN_MODE,
    input wire logic       MUX_32,
    input wire logic [1:0] BIAS_LEVELS,
    input wire logic       FOUR_BIT,
    input wire logic       FRAME_TICK,
    input wire logic [7:0] INSTR_OUT,
    input wire logic       INSTR_STB
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    logic [15:0] gap_reg;
    logic        seen_reg;
    logic        rd;
    assign rd = ENABLE && RW;
    always_ff @(posedge MCLK) begin
        gap_reg  <= (RST || FRAME_TICK) ? 16'h0000 : gap_reg + 16'h0001;
        seen_reg <= !RST && (seen_reg || FRAME_TICK);
    end
    chk_oe_idle: assert property (
        !rd && !$past(rd) && !$past(rd, 2) |-> HOST_DATA_LINES_OE == 8'h00)
        else $error("bus driven outside a read");
    chk_oe_width: assert property (
        rd && $past(rd) |-> HOST_DATA_LINES_OE == (FOUR_BIT ? 8'hf0 : 8'hff))
        else $error("read drive width wrong");
    chk_status_word: assert property (
        rd && $past(rd) && !REG_CHOOSE_LINE && !FOUR_BIT && $stable(BUSY)
        && $stable(ADDR_COUNTER) |-> HOST_DATA_LINES_OUT == {BUSY, ADDR_COUNTER})
        else $error("status word wrong");
    chk_init_busy: assert property ($past(RST) |-> BUSY)
        else $error("not busy after reset");
    chk_busy_cmd: assert property (INSTR_STB |-> BUSY)
        else $error("not busy after instruction");
    chk_refuse_busy: assert property (INSTR_STB |-> !$past(BUSY))
        else $error("instruction taken while busy");
    chk_func_bits: assert property (
        INSTR_STB && INSTR_OUT[7:5] == 3'b001 |=> GEN_MODE == INSTR_OUT[0]
        && MUX_32 == INSTR_OUT[2] && FOUR_BIT != INSTR_OUT[4])
        else $error("function bits not stored");
    chk_bias_mux: assert property (BIAS_LEVELS == (MUX_32 ? BIAS_6 : BIAS_5))
        else $error("bias does not follow mux");
    chk_sub_addr: assert property (
        !$past(RST) && $stable(SUBADDR_PIN) |-> SERIAL_ADDR == {SADDR_HIGH, SUBADDR_PIN})
        else $error("sub-address not followed");
    chk_frame_gap: assert property (
        seen_reg |-> gap_reg < FRAME_LEN && (!FRAME_TICK || gap_reg == FRAME_LEN - 1))
        else $error("frame tick spacing wrong");
endmodule
bind clhp_top clhp_sva #(.FRAME_LEN(FRAME_LEN)) i_clhp_sva (.MCLK, .RST, .ENABLE,
    .REG_CHOOSE_LINE, .RW, .HOST_DATA_LINES_OUT, .HOST_DATA_LINES_OE, .SUBADDR_PIN,
    .SERIAL_ADDR, .BUSY, .ADDR_COUNTER, .GEN_MODE, .MUX_32, .BIAS_LEVELS, .FOUR_BIT,
    .FRAME_TICK, .INSTR_OUT, .INSTR_STB);
`default_nettype wire

// file: testbench/clhp_host.sv
`default_nettype none
module clhp_host (
    input  wire logic       mclk,
    input  wire logic       nib,
    input  wire logic [7:0] dout,
    input  wire logic [7:0] doe,
    output logic            en,
    output logic            rs,
    output logic            rw,
    output logic      [7:0] bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] drv = 8'h00;
    logic [7:0] val = 8'h00;
    // Pull-ups win on lines nobody drives
    assign bus = (doe & dout) | (~doe & drv & val) | (~doe & ~drv);
    initial begin
        en = 1'b0;
        rs = 1'b1;
        rw = 1'b1;
    end
    task automatic xfer(input logic s, input logic r, input logic [7:0] w,
                        input int hold, output logic [7:0] q);
        @(posedge mclk) #1;
        en = 1'b1;
        rs = s;
        rw = r;
        val = w;
        drv = r ? 8'h00 : (nib ? 8'hf0 : 8'hff);
        repeat (hold) @(posedge mclk);
        #1 q = bus;
        en = 1'b0;
        // Selects and data held past the synchroniser's capture edge
        repeat (4) @(posedge mclk);
        #1 drv = 8'h00;
        repeat (2) @(posedge mclk);
        #2;
    endtask
endmodule
`default_nettype wire

// file: testbench/clhp_top_test.sv
`default_nettype none
module clhp_top_test import clhp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic       MCLK = 1'b0, RST = 1'b1, ENABLE, REG_CHOOSE_LINE, RW, SUBADDR_PIN = 1'b0;
    logic       BUSY, GEN_MODE, MUX_32, FOUR_BIT, FRAME_TICK, INSTR_STB, nib = 1'b0;
    logic [7:0] HOST_DATA_LINES_IN, HOST_DATA_LINES_OUT, HOST_DATA_LINES_OE, INSTR_OUT;
    logic [6:0] SERIAL_ADDR, ADDR_COUNTER;
    logic [1:0] BIAS_LEVELS;
    logic [7:0] q, q2;
    int         error_cnt = 0, cmp_count = 0, cyc = 0, stb = 0, ticks = 0;
    clhp_top #(.INIT_LEN(40), .BUSY_LEN(4), .FRAME_LEN(16)) i_clhp_top (.MCLK, .RST,
        .ENABLE, .REG_CHOOSE_LINE, .RW, .HOST_DATA_LINES_IN, .HOST_DATA_LINES_OUT,
        .HOST_DATA_LINES_OE, .SUBADDR_PIN, .SERIAL_ADDR, .BUSY, .ADDR_COUNTER, .GEN_MODE,
        .MUX_32, .BIAS_LEVELS, .FOUR_BIT, .FRAME_TICK, .INSTR_OUT, .INSTR_STB);
    clhp_host i_clhp_host (.mclk(MCLK), .nib(nib), .dout(HOST_DATA_LINES_OUT),
        .doe(HOST_DATA_LINES_OE), .en(ENABLE), .rs(REG_CHOOSE_LINE), .rw(RW),
        .bus(HOST_DATA_LINES_IN));
    initial begin
        forever #20 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        cyc++;
        stb += INSTR_STB;
        ticks += FRAME_TICK;
        if (cyc == 4000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic s, input logic [7:0] w);
        for (int n = 0; n < 100 && BUSY !== 1'b0; n++) @(posedge MCLK) #1;
        i_clhp_host.xfer(s, 1'b0, w, 2, q2);
        for (int n = 0; n < 100 && BUSY !== 1'b0; n++) @(posedge MCLK) #1;
    endtask
    task automatic end_of_test();
        $display("Compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge MCLK);
        #1 RST = 1'b0;
        chk({BUSY, ADDR_COUNTER}, {1'b1, AC_RESET});
        chk({FOUR_BIT, GEN_MODE, MUX_32, BIAS_LEVELS}, {3'b000, BIAS_5});
        SUBADDR_PIN = 1'b1;
        i_clhp_host.xfer(RS_INSTR, 1'b0, 8'h35, 2, q);
        chk({GEN_MODE, 6'h00, 1'b0} | stb, 8'h00);
        i_clhp_host.xfer(RS_INSTR, RW_READ, 8'h00, 2, q);
        chk(q[7], 1'b1);
        chk({1'b0, SERIAL_ADDR}, {1'b0, SADDR_HIGH, 1'b1});
        wr(RS_INSTR, 8'h35);
        chk({INSTR_OUT}, 8'h35);
        chk({GEN_MODE, MUX_32, BIAS_LEVELS, FOUR_BIT}, {2'b11, BIAS_6, 1'b0});
        wr(RS_INSTR, 8'h85);
        i_clhp_host.xfer(RS_INSTR, RW_READ, 8'h00, 5, q);
        chk(q, 8'h05);
        wr(1'b1, 8'h41);
        chk(stb[7:0], 8'd2);
        chk({1'b0, ADDR_COUNTER}, 8'h06);
        wr(RS_INSTR, 8'h85);
        i_clhp_host.xfer(1'b1, RW_READ, 8'h00, 2, q);
        chk(q, 8'h41);
        wr(RS_INSTR, 8'h25);
        chk({FOUR_BIT, MUX_32, GEN_MODE}, 3'b111);
        nib = 1'b1;
        i_clhp_host.xfer(RS_INSTR, 1'b0, 8'h90, 2, q);
        wr(RS_INSTR, 8'h30);
        chk(INSTR_OUT, 8'h93);
        i_clhp_host.xfer(RS_INSTR, RW_READ, 8'h00, 2, q);
        i_clhp_host.xfer(RS_INSTR, RW_READ, 8'h00, 2, q2);
        chk({q[7:4], q2[7:4]}, 8'h13);
        ticks = 0;
        repeat (64) @(posedge MCLK);
        chk(ticks[7:0], 8'd4);
        end_of_test();
    end
endmodule
`default_nettype wire
